// file: src/current_temp_status_regs.sv
/*
 * Paged output-current and temperature status bytes for a two-channel
 * controller, read by the serial command core through a simple command,
 * page and read-strobe port.
 * Assumes the command core presents the current page and command code
 * with a one-cycle read strobe, and that detection inputs are asynchronous.
 */
`timescale 1ns/1ps
`include "status_regs_params.svh"

// Behaviour
// - each channel has its own output-current status byte; page 0 is channel 1, page 1 channel 2.
// - page value 3 makes a status access apply to both channels at once.
// - output-current byte bit 7 is set when the channel's over-current fault input is seen.
// - output-current byte bit 5 is set when the channel's over-current warning input is seen.
// - the fault and warning conditions come in as separate input signals and set their own bits.
// - each channel has its own temperature status byte selected by the same page values.
// - temperature byte bit 7 reads 1 once an over-temperature fault has occurred on that channel.
// - temperature byte bit 6 reads 1 once an over-temperature warning has occurred on its channel.
// - both status bytes reset to all zeros.
module current_temp_status_regs (
    // clock and reset
    input  wire logic       MCLK,
    input  wire logic       RSTN,
    // command core side
    input  wire logic [7:0] PAGE,
    input  wire logic [7:0] CMD_CODE,
    input  wire logic       RD_REQ,
    input  wire logic       CLR_REQ,
    // detection inputs, bit 0 channel 1, bit 1 channel 2
    input  wire logic [1:0] OVERCURRENT_FAULT_FLAG,
    input  wire logic [1:0] OVERCURRENT_WARNING_FLAG,
    input  wire logic [1:0] OVERTEMP_FAULT_FLAG,
    input  wire logic [1:0] OVERTEMP_WARNING_FLAG,
    // read answer
    output logic [7:0]      RD_DATA,
    output logic            RD_VALID,
    output logic            RD_UNSUPPORTED
);

    status_regs_pkg::rd_state_t  state;
    status_regs_pkg::rd_state_t  next_state;
    status_regs_pkg::chan_mask_t clr_mask;
    status_regs_pkg::chan_mask_t rd_mask;
    logic [7:0]                  iout_byte [2];
    logic [7:0]                  temp_byte [2];
    logic [7:0]                  next_rd_data;
    logic                        next_rd_valid;
    logic                        next_rd_unsupported;
    logic [7:0]                  sel_data;
    logic                        cmd_ok;

    // ------------------------------------------------------------------
    // page decode
    // ------------------------------------------------------------------
    // one decoder shared by reads and clears so both see the same pages
    function automatic status_regs_pkg::chan_mask_t page_mask(input logic [7:0] page);
        case (page)
            `PAGE_CH1:  page_mask = 2'b01;
            `PAGE_CH2:  page_mask = 2'b10;
            `PAGE_BOTH: page_mask = 2'b11;
            default:    page_mask = 2'b00;
        endcase
    endfunction

    assign rd_mask  = page_mask(PAGE);
    assign clr_mask = CLR_REQ ? page_mask(PAGE) : 2'b00;

    // ------------------------------------------------------------------
    // per-channel status flags
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            status_channel u_chan (
                .clk                      (MCLK),
                .rst_n                    (RSTN),
                .overcurrent_fault_flag   (OVERCURRENT_FAULT_FLAG[ch]),
                .overcurrent_warning_flag (OVERCURRENT_WARNING_FLAG[ch]),
                .overtemp_fault_flag      (OVERTEMP_FAULT_FLAG[ch]),
                .overtemp_warning_flag    (OVERTEMP_WARNING_FLAG[ch]),
                .clr                      (clr_mask[ch]),
                .iout_byte                (iout_byte[ch]),
                .temp_byte                (temp_byte[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // with both pages selected the bytes are merged, so a flag on either
    // channel shows; the host cannot tell which channel raised it
    always_comb begin
        sel_data = `STATUS_RESET;
        cmd_ok   = 1'b1;
        case (CMD_CODE)
            `CMD_OUTPUT_CURRENT_STATUS: begin
                if (rd_mask[0]) sel_data = sel_data | iout_byte[0];
                if (rd_mask[1]) sel_data = sel_data | iout_byte[1];
            end
            `CMD_TEMPERATURE_STATUS: begin
                if (rd_mask[0]) sel_data = sel_data | temp_byte[0];
                if (rd_mask[1]) sel_data = sel_data | temp_byte[1];
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
        if (rd_mask == 2'b00) begin
            cmd_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read answer sequencer
    // ------------------------------------------------------------------
    // the answer is registered so every output comes from a flip-flop;
    // a request in the answer cycle is still taken, allowing back to back
    always_comb begin
        next_state          = status_regs_pkg::RD_IDLE;
        next_rd_data        = `STATUS_RESET;
        next_rd_valid       = 1'b0;
        next_rd_unsupported = 1'b0;
        case (state)
            status_regs_pkg::RD_IDLE,
            status_regs_pkg::RD_ANSWER: begin
                if (RD_REQ) begin
                    next_state          = status_regs_pkg::RD_ANSWER;
                    next_rd_valid       = 1'b1;
                    next_rd_data        = cmd_ok ? sel_data : `STATUS_RESET;
                    next_rd_unsupported = !cmd_ok;
                end
            end
            default: begin
                next_state = status_regs_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            state          <= status_regs_pkg::RD_IDLE;
            RD_DATA        <= `STATUS_RESET;
            RD_VALID       <= 1'b0;
            RD_UNSUPPORTED <= 1'b0;
        end else begin
            state          <= next_state;
            RD_DATA        <= next_rd_data;
            RD_VALID       <= next_rd_valid;
            RD_UNSUPPORTED <= next_rd_unsupported;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_read_latency: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ |=> RD_VALID)
        else $error("read request not answered in one cycle");

    a_valid_cause: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_VALID |-> $past(RD_REQ))
        else $error("read answer without request");

    a_page1_temp: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_CH2 && CMD_CODE == `CMD_TEMPERATURE_STATUS
        |=> RD_DATA == $past(temp_byte[1]) && !RD_UNSUPPORTED)
        else $error("page 1 temperature read returned wrong byte");

    a_both_merge: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_BOTH && CMD_CODE == `CMD_OUTPUT_CURRENT_STATUS
        |=> RD_DATA == ($past(iout_byte[0]) | $past(iout_byte[1])))
        else $error("both-page read did not merge channels");

    a_bad_page: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && rd_mask == 2'b00 |=> RD_UNSUPPORTED && RD_DATA == 8'h00)
        else $error("unsupported page not flagged");

    a_reset_clear: assert property (@(posedge MCLK)
        !RSTN |=> iout_byte[0] == 8'h00 && temp_byte[1] == 8'h00 && !RD_VALID)
        else $error("status not zero after reset");

    // ------------------------------------------------------------------
    // answer routing and clear selection
    // ------------------------------------------------------------------
    a_page0_iout: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_CH1 && CMD_CODE == `CMD_OUTPUT_CURRENT_STATUS
        |=> RD_DATA == $past(iout_byte[0]) && !RD_UNSUPPORTED)
        else $error("page 0 output-current read returned wrong byte");

    a_page1_iout: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_CH2 && CMD_CODE == `CMD_OUTPUT_CURRENT_STATUS
        |=> RD_DATA == $past(iout_byte[1]) && !RD_UNSUPPORTED)
        else $error("page 1 output-current read returned wrong byte");

    a_page0_temp: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_CH1 && CMD_CODE == `CMD_TEMPERATURE_STATUS
        |=> RD_DATA == $past(temp_byte[0]) && !RD_UNSUPPORTED)
        else $error("page 0 temperature read returned wrong byte");

    a_both_temp: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && PAGE == `PAGE_BOTH && CMD_CODE == `CMD_TEMPERATURE_STATUS
        |=> RD_DATA == ($past(temp_byte[0]) | $past(temp_byte[1])))
        else $error("both-page temperature read did not merge channels");

    a_temp_known: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && rd_mask != 2'b00 && CMD_CODE == `CMD_TEMPERATURE_STATUS
        |=> RD_VALID && !RD_UNSUPPORTED)
        else $error("supported temperature read flagged as unsupported");

    a_bad_cmd: assert property (@(posedge MCLK) disable iff (!RSTN)
        RD_REQ && CMD_CODE != `CMD_OUTPUT_CURRENT_STATUS
        && CMD_CODE != `CMD_TEMPERATURE_STATUS |=> RD_UNSUPPORTED && RD_DATA == 8'h00)
        else $error("unknown command not flagged");

    a_idle_quiet: assert property (@(posedge MCLK) disable iff (!RSTN)
        !RD_VALID |-> RD_DATA == 8'h00 && !RD_UNSUPPORTED)
        else $error("answer outputs not idle outside an answer");

    // a clear aimed elsewhere must never drop a latched channel 1 bit
    a_clear_keep: assert property (@(posedge MCLK) disable iff (!RSTN)
        CLR_REQ && !clr_mask[0]
        |=> (iout_byte[0] & $past(iout_byte[0])) == $past(iout_byte[0])
            && (temp_byte[0] & $past(temp_byte[0])) == $past(temp_byte[0]))
        else $error("clear of another page dropped a channel 1 flag");

endmodule

// file: src/status_channel.sv
/*
 * One channel's sticky status flags: two-stage synchronisers on the four
 * detection inputs and the latched fault and warning bits.
 * Assumes asynchronous flag inputs and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "status_regs_params.svh"

module status_channel (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // raw detection inputs
    input  wire logic       overcurrent_fault_flag,
    input  wire logic       overcurrent_warning_flag,
    input  wire logic       overtemp_fault_flag,
    input  wire logic       overtemp_warning_flag,
    // clear strobe for this channel
    input  wire logic       clr,
    // status bytes
    output logic [7:0]      iout_byte,
    output logic [7:0]      temp_byte
);

    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] flags;
    logic [3:0] next_sync1;
    logic [3:0] next_sync2;
    logic [3:0] next_flags;

    // ------------------------------------------------------------------
    // synchroniser and sticky flags
    // ------------------------------------------------------------------
    // flags: [0] oc fault, [1] oc warn, [2] ot fault, [3] ot warn
    always_comb begin
        next_sync1 = {overtemp_warning_flag, overtemp_fault_flag,
                      overcurrent_warning_flag, overcurrent_fault_flag};
        next_sync2 = sync1;
        // set beats clear so an event landing on a clear is kept
        next_flags = (clr ? 4'h0 : flags) | sync2;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            flags <= 4'h0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // byte assembly, unused positions tied low
    // ------------------------------------------------------------------
    always_comb begin
        iout_byte                = `STATUS_RESET;
        iout_byte[`BIT_OC_FAULT] = flags[0];
        iout_byte[`BIT_OC_WARN]  = flags[1];
        temp_byte                = `STATUS_RESET;
        temp_byte[`BIT_OT_FAULT] = flags[2];
        temp_byte[`BIT_OT_WARN]  = flags[3];
    end

    a_oc_fault_set: assert property (@(posedge clk) disable iff (!rst_n)
        sync2[0] |=> iout_byte[`BIT_OC_FAULT])
        else $error("oc fault bit not set after synced fault");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        temp_byte[`BIT_OT_FAULT] && !clr |=> temp_byte[`BIT_OT_FAULT])
        else $error("ot fault bit dropped without clear");

    a_input_latency: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(overcurrent_warning_flag) ##0 !iout_byte[`BIT_OC_WARN] ##1
        overcurrent_warning_flag |-> ##2 iout_byte[`BIT_OC_WARN])
        else $error("oc warning not set three cycles after input");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        iout_byte[6] == 1'b0 && iout_byte[4:0] == 5'h00 && temp_byte[5:0] == 6'h00)
        else $error("reserved status bits not zero");

endmodule

// file: src/status_regs_params.svh
/*
 * Constants for the paged output-current and temperature status bytes:
 * command codes, bit positions, reset values and page values.
 * Assumes it is included by bare name from the files that need it.
 */
`ifndef STATUS_REGS_PARAMS_SVH
`define STATUS_REGS_PARAMS_SVH

// ----------------------------------------------------------------------
// command codes of the two status bytes
// ----------------------------------------------------------------------
`define CMD_OUTPUT_CURRENT_STATUS 8'h7B
`define CMD_TEMPERATURE_STATUS    8'h7D

// ----------------------------------------------------------------------
// bit positions inside the status bytes
// ----------------------------------------------------------------------
`define BIT_OC_FAULT 7
`define BIT_OC_WARN  5
`define BIT_OT_FAULT 7
`define BIT_OT_WARN  6

// ----------------------------------------------------------------------
// reset values and page values
// ----------------------------------------------------------------------
`define STATUS_RESET 8'h00
`define PAGE_CH1     8'h00
`define PAGE_CH2     8'h01
`define PAGE_BOTH    8'h03
`define SYNC_STAGES  2

`endif

// file: src/status_regs_pkg.sv
/*
 * Types shared by the status register bank.
 * Assumes nothing of its surroundings.
 */
package status_regs_pkg;

    // read answer sequencer, gray coded
    typedef enum logic [1:0] {
        RD_IDLE   = 2'b00,
        RD_ANSWER = 2'b01
    } rd_state_t;

    // one bit per channel: bit 0 channel 1, bit 1 channel 2
    typedef logic [1:0] chan_mask_t;

endpackage

// file: verif/pmbus_host_model.sv
/*
 * Host-side model of the serial command core: places page, command code
 * and one-cycle read or clear strobes on the status bank's request port.
 * Assumes a single rising-edge clock shared with the status bank.
 */
`timescale 1ns/1ps

module pmbus_host_model (
    // clock
    input  wire logic       mclk,
    // request side
    output logic [7:0]      page,
    output logic [7:0]      cmd_code,
    output logic            rd_req,
    output logic            clr_req,
    // answer side
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire logic       rd_unsupported
);
    // ------------------------------------------------------------------
    // request tasks
    // ------------------------------------------------------------------
    // idle port at time zero so nothing is taken during reset
    initial begin
        page     = 8'h00;
        cmd_code = 8'h00;
        rd_req   = 1'b0;
        clr_req  = 1'b0;
    end

    // one read; answer is taken 1 ns after the taking edge
    task automatic read(input logic [7:0] pg, input logic [7:0] cmd,
                        output logic [7:0] data, output logic unsup, output logic seen);
        @(posedge mclk);
        page     <= pg;
        cmd_code <= cmd;
        rd_req   <= 1'b1;
        @(posedge mclk);
        rd_req   <= 1'b0;
        #1; // let the answer registers settle
        seen     = rd_valid;
        data     = rd_data;
        unsup    = rd_unsupported;
    endtask

    // clear of the sticky flags of the selected page
    task automatic clear(input logic [7:0] pg);
        @(posedge mclk);
        page    <= pg;
        clr_req <= 1'b1;
        @(posedge mclk);
        clr_req <= 1'b0;
    endtask
endmodule

// file: verif/test_current_temp_status_regs.sv
/*
 * Self-checking bench for the paged status bytes: reset values, each flag
 * per channel, both-page access, clear and unsupported accesses.
 * Assumes the host model file is compiled before this one.
 */
`timescale 1ns/1ps
`include "status_regs_params.svh"

module test_current_temp_status_regs;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] page;
    logic [7:0] cmd_code;
    logic       rd_req;
    logic       clr_req;
    logic [1:0] flags [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_unsupported;
    int         n_mismatch = 0;
    int         tests_run  = 0;

    // ------------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------------
    always #12.5 mclk = ~mclk;

    current_temp_status_regs u_dut (.MCLK(mclk), .RSTN(rstn), .PAGE(page),
        .CMD_CODE(cmd_code), .RD_REQ(rd_req), .CLR_REQ(clr_req),
        .OVERCURRENT_FAULT_FLAG(flags[0]), .OVERCURRENT_WARNING_FLAG(flags[1]),
        .OVERTEMP_FAULT_FLAG(flags[2]), .OVERTEMP_WARNING_FLAG(flags[3]),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_UNSUPPORTED(rd_unsupported));

    pmbus_host_model u_host (.mclk(mclk), .page(page), .cmd_code(cmd_code),
        .rd_req(rd_req), .clr_req(clr_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_unsupported(rd_unsupported));

    // ------------------------------------------------------------------
    // shared checks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
            n_mismatch++;
        end
    endtask

    // read and compare byte plus strobe and unsupported flag together
    task automatic rd_check(input logic [7:0] pg, input logic [7:0] cmd,
                            input logic [7:0] exp, input logic exp_unsup);
        logic [7:0] data;
        logic       unsup;
        logic       seen;
        u_host.read(pg, cmd, data, unsup, seen);
        check(data, exp, "read byte");
        check({6'h00, seen, unsup}, {6'h00, 1'b1, exp_unsup}, "answer strobe");
    endtask

    // status bit of flag input f, in the byte of its own command
    function automatic logic [7:0] flag_mask(input int f);
        case (f)
            0: flag_mask = 8'h01 << `BIT_OC_FAULT;
            1: flag_mask = 8'h01 << `BIT_OC_WARN;
            2: flag_mask = 8'h01 << `BIT_OT_FAULT;
            default: flag_mask = 8'h01 << `BIT_OT_WARN;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // every page and command reads zero after reset
    task automatic t_reset;
        logic [7:0] pages [3] = '{`PAGE_CH1, `PAGE_CH2, `PAGE_BOTH};
        foreach (pages[i]) begin
            rd_check(pages[i], `CMD_OUTPUT_CURRENT_STATUS, `STATUS_RESET, 1'b0);
            rd_check(pages[i], `CMD_TEMPERATURE_STATUS, `STATUS_RESET, 1'b0);
        end
    endtask

    // one pulse per flag and channel; bit must stick after the input drops
    task automatic t_single_flags;
        logic [7:0] cmd;
        logic [7:0] other;
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 4; f++) begin
                cmd   = (f < 2) ? `CMD_OUTPUT_CURRENT_STATUS : `CMD_TEMPERATURE_STATUS;
                other = (f < 2) ? `CMD_TEMPERATURE_STATUS : `CMD_OUTPUT_CURRENT_STATUS;
                @(posedge mclk);
                flags[f] <= 2'h1 << ch;
                repeat (3) @(posedge mclk); // two sync stages plus the flag register
                flags[f] <= 2'h0;
                rd_check(8'(ch), cmd, flag_mask(f), 1'b0);
                rd_check(8'(1 - ch), cmd, 8'h00, 1'b0);
                rd_check(`PAGE_BOTH, cmd, flag_mask(f), 1'b0);
                rd_check(8'(ch), other, 8'h00, 1'b0);
                u_host.clear(8'(ch));
                rd_check(8'(ch), cmd, 8'h00, 1'b0);
            end
        end
    endtask

    // distinct flags on the two channels merge on the both page
    task automatic t_both_pages;
        @(posedge mclk);
        flags[0] <= 2'h1;
        flags[1] <= 2'h2;
        repeat (3) @(posedge mclk);
        flags[0] <= 2'h0;
        flags[1] <= 2'h0;
        rd_check(`PAGE_CH1, `CMD_OUTPUT_CURRENT_STATUS, 8'h80, 1'b0);
        rd_check(`PAGE_CH2, `CMD_OUTPUT_CURRENT_STATUS, 8'h20, 1'b0);
        rd_check(`PAGE_BOTH, `CMD_OUTPUT_CURRENT_STATUS, 8'hA0, 1'b0);
        u_host.clear(`PAGE_BOTH);
        rd_check(`PAGE_CH1, `CMD_OUTPUT_CURRENT_STATUS, 8'h00, 1'b0);
        rd_check(`PAGE_CH2, `CMD_OUTPUT_CURRENT_STATUS, 8'h00, 1'b0);
    endtask

    // unknown page or command answers zero and is flagged
    task automatic t_unsupported;
        rd_check(8'h02, `CMD_OUTPUT_CURRENT_STATUS, 8'h00, 1'b1);
        rd_check(`PAGE_CH1, 8'h7C, 8'h00, 1'b1);
        // a clear of a bad page or of channel 2 leaves channel 1 latched
        @(posedge mclk);
        flags[2] <= 2'h1;
        repeat (3) @(posedge mclk);
        flags[2] <= 2'h0;
        u_host.clear(8'h02);
        rd_check(`PAGE_CH1, `CMD_TEMPERATURE_STATUS, 8'h80, 1'b0);
        u_host.clear(`PAGE_CH2);
        rd_check(`PAGE_CH1, `CMD_TEMPERATURE_STATUS, 8'h80, 1'b0);
    endtask

    // a reset in mid-run drops every latched flag on both channels
    task automatic t_reset_mid;
        @(posedge mclk);
        flags[1] <= 2'h3;
        repeat (3) @(posedge mclk);
        flags[1] <= 2'h0;
        rd_check(`PAGE_BOTH, `CMD_OUTPUT_CURRENT_STATUS, 8'h20, 1'b0);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd_check(`PAGE_BOTH, `CMD_OUTPUT_CURRENT_STATUS, `STATUS_RESET, 1'b0);
        rd_check(`PAGE_BOTH, `CMD_TEMPERATURE_STATUS, `STATUS_RESET, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // sequence, verdict and watchdog
    // ------------------------------------------------------------------
    task automatic summarize;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_single_flags();
        t_both_pages();
        t_unsupported();
        t_reset_mid();
        summarize();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #(25 * 5000);
        n_mismatch++;
        summarize();
    end
endmodule
